// [tb/fsp_core_model.sv]
// core model issuing data-move and code-read cycles
`timescale 1ns/1ps
module fsp_core_model (
	input wire clk_i,
	input wire [7:0] code_rdata_i,
	output reg [15:0] xm_addr_o = 16'h0000,
	output reg [7:0] xm_wdata_o = 8'h00,
	output reg xm_wr_o = 1'b0,
	output reg xm_rd_o = 1'b0,
	output reg [15:0] code_addr_o = 16'h0000,
	output reg code_rd_o = 1'b0,
	output reg code_fetch_o = 1'b0
);
	// this core takes no interrupts while it programs
	task mv(input w, input [15:0] a, input [7:0] d);
	begin
		xm_addr_o <= a;
		xm_wdata_o <= d;
		xm_wr_o <= w;
		xm_rd_o <= !w;
		@(posedge clk_i);
		xm_wr_o <= 1'b0;
		xm_rd_o <= 1'b0;
		xm_addr_o <= ~a;
		xm_wdata_o <= ~d;
	end
	endtask
	task cread(input [15:0] a, input f, output [7:0] d);
	begin
		code_addr_o <= a;
		code_fetch_o <= f;
		code_rd_o <= 1'b1;
		@(posedge clk_i);
		code_rd_o <= 1'b0;
		code_addr_o <= ~a;
		#1;
		d = code_rdata_i;
		@(posedge clk_i);
	end
	endtask
endmodule // fsp_core_model

// [tb/fsp_properties.sv]
// port assertions for the flash program and erase sequencer
`timescale 1ns/1ps
`include "fsp_defines.vh"
module fsp_properties (
	input wire clk_i,
	input wire nrst_i,
	input wire [`FSP_REG_AW-1:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	input wire [7:0] reg_rdata_o,
	input wire [`FSP_ADDR_W-1:0] xm_addr_i,
	input wire xm_wr_i,
	input wire xm_rd_i,
	input wire [`FSP_ADDR_W-1:0] ram_addr_o,
	input wire ram_wr_o,
	input wire ram_rd_o,
	input wire tp_wr_i,
	input wire tp_erase_i,
	input wire [`FSP_INT_W-1:0] irq_o,
	input wire stall_o,
	input wire busy_o
);
	// shadows of control bits rebuilt from the bus, since the block hides them
	reg [2:0] ctl_q;
	reg gate_q;
	reg ers_q;
	reg [9:0] bcnt_q;
	wire go = xm_wr_i && ctl_q[0] && gate_q && !busy_o;
	always @(posedge clk_i)
	begin
		ctl_q <= !nrst_i ? 3'h0 : (reg_wr_i && reg_addr_i == 2'h0) ? reg_wdata_i[2:0] : ctl_q;
		gate_q <= !nrst_i ? 1'b0 : (reg_wr_i && reg_addr_i == 2'h1) ? reg_wdata_i[0] : gate_q;
		ers_q <= go ? ctl_q[1] : ((tp_wr_i || tp_erase_i) && !busy_o) ? tp_erase_i : ers_q;
		bcnt_q <= (busy_o && nrst_i) ? bcnt_q + 10'h001 : 10'h000;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	AST_RAM_RD: assert property (xm_rd_i |-> ram_rd_o && ram_addr_o == xm_addr_i)
		else $error("data-move read not passed to ram");
	AST_REDIR: assert property (xm_wr_i |-> ram_wr_o == !ctl_q[0])
		else $error("data-move write routed wrongly");
	AST_PROG_GO: assert property (go && !ctl_q[1] |=> busy_o && stall_o)
		else $error("program write did not start");
	AST_GATE: assert property (xm_wr_i && !gate_q && !busy_o && !tp_wr_i && !tp_erase_i |=> !busy_o)
		else $error("flash op started with gate closed");
	AST_STALL: assert property (busy_o |-> stall_o ##1 (stall_o == busy_o))
		else $error("core not stalled while busy");
	AST_IRQ: assert property (busy_o |-> irq_o == 8'h00)
		else $error("interrupt passed while busy");
	AST_WR_TIME: assert property ($fell(busy_o) && !ers_q |-> bcnt_q == 10'h190)
		else $error("program time wrong");
	AST_ER_TIME: assert property ($fell(busy_o) && ers_q |-> bcnt_q >= 10'h080)
		else $error("erase too short");
	AST_CTL_RD: assert property (reg_rd_i && reg_addr_i == 2'h0 |=> reg_rdata_o == {5'h00, ctl_q})
		else $error("control readback wrong");
endmodule // fsp_properties
bind fsp_flash_seq fsp_properties chk_u (.clk_i(clk_i), .nrst_i(nrst_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .xm_addr_i(xm_addr_i), .xm_wr_i(xm_wr_i),
	.xm_rd_i(xm_rd_i), .ram_addr_o(ram_addr_o), .ram_wr_o(ram_wr_o), .ram_rd_o(ram_rd_o),
	.tp_wr_i(tp_wr_i), .tp_erase_i(tp_erase_i), .irq_o(irq_o), .stall_o(stall_o),
	.busy_o(busy_o));

// [tb/tb_top.sv]
// testbench for the flash program and erase sequencer
`timescale 1ns/1ps
module tb_top;
	reg clk_i = 1'b0;
	reg nrst_i = 1'b0;
	reg [1:0] ra = 2'h0;
	reg [7:0] wd = 8'h00;
	reg we = 1'b0;
	reg re = 1'b0;
	reg tpw = 1'b0;
	reg [15:0] tpa = 16'h0000;
	reg [7:0] tpd = 8'h00;
	reg [7:0] irq = 8'h00;
	reg [7:0] ack = 8'h00;
	wire [15:0] xa, ca;
	wire [7:0] xd, cd, rd, iro;
	wire xw, xr, cs, cf, busy;
	wire stall, rw, rr;
	reg tpe = 1'b0;
	// start opposite to what each scenario expects so a dead path cannot pass
	reg rw_seen = 1'b1;
	reg rr_seen = 1'b0;
	integer error_cnt = 0;
	integer checks = 0;
	always #50 clk_i = ~clk_i;
	always @(posedge clk_i)
	begin
		if (xw)
			rw_seen <= rw;
		if (xr)
			rr_seen <= rr;
	end
	fsp_flash_seq #(.ERASE_CYC(17'h00014)) dut_u (.clk_i(clk_i), .nrst_i(nrst_i),
		.reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(we), .reg_rd_i(re), .reg_rdata_o(rd),
		.xm_addr_i(xa), .xm_wdata_i(xd), .xm_wr_i(xw), .xm_rd_i(xr), .ram_addr_o(),
		.ram_wdata_o(), .ram_wr_o(rw), .ram_rd_o(rr), .code_addr_i(ca), .code_rd_i(cs),
		.code_fetch_i(cf), .code_rdata_o(cd), .tp_wr_i(tpw), .tp_erase_i(tpe),
		.tp_addr_i(tpa), .tp_wdata_i(tpd), .irq_i(irq), .irq_ack_i(ack), .irq_o(iro),
		.stall_o(stall), .busy_o(busy));
	fsp_core_model core_u (.clk_i(clk_i), .code_rdata_i(cd), .xm_addr_o(xa), .xm_wdata_o(xd),
		.xm_wr_o(xw), .xm_rd_o(xr), .code_addr_o(ca), .code_rd_o(cs), .code_fetch_o(cf));
	task test_done;
	begin
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end
	endtask
	task chk(input [7:0] got, input [7:0] exp);
	begin
		checks = checks + 1;
		if (got !== exp)
		begin
			error_cnt = error_cnt + 1;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask
	task reg_w(input [1:0] a, input [7:0] d);
	begin
		ra <= a;
		wd <= d;
		we <= 1'b1;
		@(posedge clk_i);
		we <= 1'b0;
		@(posedge clk_i);
	end
	endtask
	task reg_r(input [1:0] a, input [7:0] exp);
	begin
		ra <= a;
		re <= 1'b1;
		@(posedge clk_i);
		re <= 1'b0;
		#1;
		chk(rd, exp);
		@(posedge clk_i);
	end
	endtask
	task cr(input [15:0] a, input f, input [7:0] exp);
		reg [7:0] v;
	begin
		core_u.cread(a, f, v);
		chk(v, exp);
	end
	endtask
	// entered just after the edge that took the request
	task wait_op;
		integer n;
	begin
		#1;
		chk({7'h00, busy}, 8'h01);
		chk({7'h00, stall}, 8'h01);
		for (n = 0; busy === 1'b1 && n < 1000; n = n + 1)
			@(posedge clk_i) #1;
		if (n == 1000)
		begin
			chk(8'h00, 8'h01);
			test_done;
		end
		@(posedge clk_i);
	end
	endtask
	task t_regs;
	begin
		reg_r(2'h0, 8'h00);
		reg_w(2'h0, 8'h07);
		reg_r(2'h0, 8'h07);
		reg_w(2'h3, 8'hFF);
		reg_r(2'h3, 8'h00);
		reg_r(2'h2, 8'h00);
	end
	endtask
	task t_gate;
	begin
		reg_w(2'h0, 8'h01);
		core_u.mv(1'b1, 16'h0200, 8'h00);
		#1;
		chk({7'h00, busy}, 8'h00);
		chk({7'h00, rw_seen}, 8'h00);
		@(posedge clk_i);
		core_u.mv(1'b0, 16'h0123, 8'h00);
		#1;
		chk({7'h00, rr_seen}, 8'h01);
		@(posedge clk_i);
	end
	endtask
	task t_prog;
	begin
		reg_w(2'h1, 8'h01);
		reg_w(2'h0, 8'h03);
		core_u.mv(1'b1, 16'h0345, 8'h00);
		irq <= 8'h05;
		@(posedge clk_i);
		irq <= 8'h00;
		wait_op;
		chk(iro, 8'h05);
		ack <= 8'h05;
		@(posedge clk_i);
		ack <= 8'h00;
		@(posedge clk_i) #1;
		chk(iro, 8'h00);
		@(posedge clk_i);
		cr(16'h0200, 1'b0, 8'hFF);
		cr(16'h03FF, 1'b0, 8'hFF);
		reg_w(2'h0, 8'h01);
		core_u.mv(1'b1, 16'h0210, 8'hA5);
		wait_op;
		core_u.mv(1'b1, 16'h0210, 8'h3C);
		wait_op;
		cr(16'h0210, 1'b0, 8'h24);
		reg_r(2'h0, 8'h01);
	end
	endtask
	task t_scratch;
	begin
		reg_w(2'h0, 8'h03);
		core_u.mv(1'b1, 16'h0000, 8'h00);
		wait_op;
		reg_w(2'h0, 8'h01);
		core_u.mv(1'b1, 16'h0005, 8'h11);
		wait_op;
		reg_w(2'h0, 8'h07);
		core_u.mv(1'b1, 16'h0005, 8'h00);
		wait_op;
		reg_w(2'h0, 8'h05);
		core_u.mv(1'b1, 16'h0005, 8'h5A);
		wait_op;
		cr(16'h0005, 1'b0, 8'h5A);
		cr(16'h007F, 1'b0, 8'hFF);
		cr(16'h0005, 1'b1, 8'h11);
		reg_w(2'h0, 8'h00);
		cr(16'h0005, 1'b0, 8'h11);
	end
	endtask
	task t_tp;
	begin
		reg_w(2'h1, 8'h00);
		tpa <= 16'h0211;
		tpd <= 8'h77;
		tpw <= 1'b1;
		@(posedge clk_i);
		tpw <= 1'b0;
		wait_op;
		cr(16'h0211, 1'b0, 8'h77);
		tpa <= 16'h0211;
		tpe <= 1'b1;
		@(posedge clk_i);
		tpe <= 1'b0;
		wait_op;
		cr(16'h0211, 1'b0, 8'hFF);
		core_u.mv(1'b1, 16'h0100, 8'h00);
		#1;
		chk({7'h00, rw_seen}, 8'h01);
		@(posedge clk_i);
	end
	endtask
	initial
	begin
		repeat (3) @(posedge clk_i);
		nrst_i <= 1'b1;
		@(posedge clk_i);
		t_regs;
		t_gate;
		t_prog;
		t_scratch;
		t_tp;
		test_done;
	end
endmodule // tb_top

// [verilog/fsp_defines.vh]
// constants for the flash software program/erase sequencer
// Summary of operation
// - flash programmable one byte at a time by software or test port
// - write and erase timed internally; software never polls
// - byte program only clears bits; old AND new stored
// - erase clears a whole 512-byte page to FF
// - with write enable set, data-move writes go to flash
// - write enable stays set until software clears it
// - data-move reads always go to external data RAM
// - flash contents return through code-read moves
// - software writes and erases happen only while the write gate is set
// - erase enable plus write enable: a write erases its page
// - write enable alone: a write programs the addressed byte
// - core is stalled while a program or erase runs
// - interrupts arriving meanwhile are held until completion
// - extra 128-byte scratch sector overlays code reads of 00 to 7F; scratch writes use the low 7 bits of any address
// - scratch sector reached only while scratch select is set
// - scratch sector erased as one 128-byte unit
// - no instruction fetch from the scratch sector
`ifndef FSP_DEFINES_VH
`define FSP_DEFINES_VH
`define FSP_ADDR_W 16
`define FSP_MAIN_DEPTH 65536
`define FSP_SCR_DEPTH 128
`define FSP_PAGE_LSB 9
`define FSP_SCR_AW 7
`define FSP_ERASED 8'hFF
`define FSP_ZERO_BYTE 8'h00
`define FSP_REG_AW 2
`define FSP_REG_PROG_STORE_CTRL 2'h0
`define FSP_REG_FLCTL 2'h1
`define FSP_REG_STAT 2'h2
`define FSP_BIT_WEN 0
`define FSP_BIT_EEN 1
`define FSP_BIT_SCR 2
`define FSP_BIT_GATE 0
`define FSP_CLK_MHZ 10
`define FSP_WRITE_US 40
`define FSP_ERASE_US 10000
`define FSP_WRITE_CYC (`FSP_WRITE_US * `FSP_CLK_MHZ)
`define FSP_ERASE_CYC (`FSP_ERASE_US * `FSP_CLK_MHZ)
`define FSP_CNT_W 17
`define FSP_INT_W 8
`endif

// [verilog/fsp_flash_seq.v]
// flash software program and erase sequencer with flash arrays
`timescale 1ns/1ps
`include "fsp_defines.vh"
module fsp_flash_seq #(
	parameter [`FSP_CNT_W-1:0] ERASE_CYC = `FSP_ERASE_CYC
)
(
	input wire clk_i,
	input wire nrst_i,
	input wire [`FSP_REG_AW-1:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [7:0] reg_rdata_o,
	input wire [`FSP_ADDR_W-1:0] xm_addr_i,
	input wire [7:0] xm_wdata_i,
	input wire xm_wr_i,
	input wire xm_rd_i,
	output wire [`FSP_ADDR_W-1:0] ram_addr_o,
	output wire [7:0] ram_wdata_o,
	output wire ram_wr_o,
	output wire ram_rd_o,
	input wire [`FSP_ADDR_W-1:0] code_addr_i,
	input wire code_rd_i,
	input wire code_fetch_i,
	output reg [7:0] code_rdata_o,
	input wire tp_wr_i,
	input wire tp_erase_i,
	input wire [`FSP_ADDR_W-1:0] tp_addr_i,
	input wire [7:0] tp_wdata_i,
	input wire [`FSP_INT_W-1:0] irq_i,
	input wire [`FSP_INT_W-1:0] irq_ack_i,
	output wire [`FSP_INT_W-1:0] irq_o,
	output wire stall_o,
	output wire busy_o
);
	reg [7:0] main_mem [0:`FSP_MAIN_DEPTH-1];
	reg [7:0] scr_mem [0:`FSP_SCR_DEPTH-1];
	reg wen_q;
	reg een_q;
	reg scr_q;
	reg gate_q;
	reg op_erase_q;
	reg op_scr_q;
	reg [`FSP_ADDR_W-1:0] op_addr_q;
	reg [7:0] op_data_q;
	reg [`FSP_ADDR_W-1:0] ers_ptr_q;
	reg ers_run_q;
	reg ers_scr_q;
	reg [7:0] code_d;
	wire busy;
	wire done;
	wire sw_hit;
	wire tp_hit;
	wire start;
	wire start_erase;
	wire start_scr;
	wire [`FSP_ADDR_W-1:0] start_addr;
	wire [7:0] start_data;
	wire [`FSP_ADDR_W-1:0] page_base;
	wire [`FSP_ADDR_W-1:0] page_last;
	wire [`FSP_ADDR_W-1:0] scr_last;
	wire [`FSP_SCR_AW-1:0] scr_idx;
	wire [`FSP_SCR_AW-1:0] code_scr_idx;
	wire code_in_scr;
	wire [`FSP_ADDR_W-1:0] one_a;

	assign one_a = {{(`FSP_ADDR_W-1){1'b0}}, 1'b1};
	// software requests need the gate and the redirect bit; test port needs neither
	assign sw_hit = xm_wr_i && wen_q && gate_q;
	assign tp_hit = (tp_wr_i || tp_erase_i) && !xm_wr_i;
	assign start = (sw_hit || tp_hit) && !busy && !ers_run_q;
	assign start_erase = sw_hit ? een_q : tp_erase_i;
	assign start_scr = sw_hit && scr_q;
	assign start_addr = sw_hit ? xm_addr_i : tp_addr_i;
	assign start_data = sw_hit ? xm_wdata_i : tp_wdata_i;
	assign page_base = {op_addr_q[`FSP_ADDR_W-1:`FSP_PAGE_LSB], {`FSP_PAGE_LSB{1'b0}}};
	assign page_last = {op_addr_q[`FSP_ADDR_W-1:`FSP_PAGE_LSB], {`FSP_PAGE_LSB{1'b1}}};
	assign scr_last = {{(`FSP_ADDR_W-`FSP_SCR_AW){1'b0}}, {`FSP_SCR_AW{1'b1}}};
	assign scr_idx = op_addr_q[`FSP_SCR_AW-1:0];
	assign code_scr_idx = code_addr_i[`FSP_SCR_AW-1:0];
	assign code_in_scr = scr_q && (code_addr_i <= scr_last);

	// data-move reads never see flash; writes bypass the RAM while redirected
	assign ram_addr_o = xm_addr_i;
	assign ram_wdata_o = xm_wdata_i;
	assign ram_rd_o = xm_rd_i;
	assign ram_wr_o = xm_wr_i && !wen_q;
	assign busy_o = busy || ers_run_q;
	assign stall_o = busy || ers_run_q;

	fsp_timer #(
		.ERASE_CYC(ERASE_CYC)
	) u_timer (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.start_i(start),
		.erase_i(start_erase),
		.busy_o(busy),
		.done_o(done)
	);

	fsp_irq_hold u_irq (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.busy_i(busy_o),
		.irq_i(irq_i),
		.irq_ack_i(irq_ack_i),
		.irq_o(irq_o)
	);

	// control registers: only software changes the enables
	always @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			wen_q <= 1'b0;
			een_q <= 1'b0;
			scr_q <= 1'b0;
			gate_q <= 1'b0;
		end
		else if (reg_wr_i)
		begin
			if (reg_addr_i == `FSP_REG_PROG_STORE_CTRL)
			begin
				wen_q <= reg_wdata_i[`FSP_BIT_WEN];
				een_q <= reg_wdata_i[`FSP_BIT_EEN];
				scr_q <= reg_wdata_i[`FSP_BIT_SCR];
			end
			if (reg_addr_i == `FSP_REG_FLCTL)
				gate_q <= reg_wdata_i[`FSP_BIT_GATE];
		end
	end

	always @(posedge clk_i)
	begin
		if (!nrst_i)
			reg_rdata_o <= `FSP_ZERO_BYTE;
		else if (reg_rd_i)
		begin
			case (reg_addr_i)
				`FSP_REG_PROG_STORE_CTRL: reg_rdata_o <= {5'h00, scr_q, een_q, wen_q};
				`FSP_REG_FLCTL: reg_rdata_o <= {7'h00, gate_q};
				`FSP_REG_STAT: reg_rdata_o <= {7'h00, busy_o};
				default: reg_rdata_o <= `FSP_ZERO_BYTE;
			endcase
		end
		else
			reg_rdata_o <= `FSP_ZERO_BYTE;
	end

	// latch the operation; memory changes when the timed cycle ends
	always @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			op_erase_q <= 1'b0;
			op_scr_q <= 1'b0;
			op_addr_q <= {`FSP_ADDR_W{1'b0}};
			op_data_q <= `FSP_ZERO_BYTE;
		end
		else if (start)
		begin
			op_erase_q <= start_erase;
			op_scr_q <= start_scr;
			op_addr_q <= start_addr;
			op_data_q <= start_data;
		end
	end

	// erase walks one byte per clock; stall covers the walk as well
	always @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			ers_run_q <= 1'b0;
			ers_scr_q <= 1'b0;
			ers_ptr_q <= {`FSP_ADDR_W{1'b0}};
		end
		else if (done && op_erase_q)
		begin
			ers_run_q <= 1'b1;
			ers_scr_q <= op_scr_q;
			ers_ptr_q <= op_scr_q ? {`FSP_ADDR_W{1'b0}} : page_base;
		end
		else if (ers_run_q)
		begin
			if (ers_ptr_q == (ers_scr_q ? scr_last : page_last))
				ers_run_q <= 1'b0;
			else
				ers_ptr_q <= ers_ptr_q + one_a;
		end
	end

	always @(posedge clk_i)
	begin
		if (ers_run_q && !ers_scr_q)
			main_mem[ers_ptr_q] <= `FSP_ERASED;
		else if (done && !op_erase_q && !op_scr_q)
			main_mem[op_addr_q] <= main_mem[op_addr_q] & op_data_q;
	end

	always @(posedge clk_i)
	begin
		if (ers_run_q && ers_scr_q)
			scr_mem[ers_ptr_q[`FSP_SCR_AW-1:0]] <= `FSP_ERASED;
		else if (done && !op_erase_q && op_scr_q)
			scr_mem[scr_idx] <= scr_mem[scr_idx] & op_data_q;
	end

	// code reads: fetches never come from the scratch sector
	always @*
	begin
		code_d = main_mem[code_addr_i];
		if (code_in_scr && !code_fetch_i)
			code_d = scr_mem[code_scr_idx];
	end

	always @(posedge clk_i)
	begin
		if (!nrst_i)
			code_rdata_o <= `FSP_ZERO_BYTE;
		else if (code_rd_i)
			code_rdata_o <= code_d;
	end
endmodule // fsp_flash_seq

// [verilog/fsp_irq_hold.v]
// holds interrupt requests pending while the flash is busy
`timescale 1ns/1ps
`include "fsp_defines.vh"
module fsp_irq_hold (
	input wire clk_i,
	input wire nrst_i,
	input wire busy_i,
	input wire [`FSP_INT_W-1:0] irq_i,
	input wire [`FSP_INT_W-1:0] irq_ack_i,
	output wire [`FSP_INT_W-1:0] irq_o
);
	reg [`FSP_INT_W-1:0] pend_q;
	genvar g;
	generate
		for (g = 0; g < `FSP_INT_W; g = g + 1)
		begin : g_pend
			// set wins over acknowledge so no event is lost
			always @(posedge clk_i)
			begin
				if (!nrst_i)
					pend_q[g] <= 1'b0;
				else if (irq_i[g])
					pend_q[g] <= 1'b1;
				else if (irq_ack_i[g])
					pend_q[g] <= 1'b0;
			end
			assign irq_o[g] = pend_q[g] & ~busy_i;
		end
	endgenerate
endmodule // fsp_irq_hold

// [verilog/fsp_timer.v]
// busy timer for flash write and erase cycles
`timescale 1ns/1ps
`include "fsp_defines.vh"
module fsp_timer #(
	parameter [`FSP_CNT_W-1:0] ERASE_CYC = `FSP_ERASE_CYC
)
(
	input wire clk_i,
	input wire nrst_i,
	input wire start_i,
	input wire erase_i,
	output wire busy_o,
	output wire done_o
);
	reg [`FSP_CNT_W-1:0] cnt_q;
	reg busy_q;
	localparam [`FSP_CNT_W-1:0] WR_CYC = `FSP_WRITE_CYC;
	localparam [`FSP_CNT_W-1:0] ONE = 1;
	assign busy_o = busy_q;
	assign done_o = busy_q && (cnt_q == ONE);
	always @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			cnt_q <= {`FSP_CNT_W{1'b0}};
			busy_q <= 1'b0;
		end
		else if (start_i && !busy_q)
		begin
			cnt_q <= erase_i ? ERASE_CYC : WR_CYC;
			busy_q <= 1'b1;
		end
		else if (busy_q)
		begin
			cnt_q <= cnt_q - ONE;
			if (cnt_q == ONE)
				busy_q <= 1'b0;
		end
	end
endmodule // fsp_timer
